// *** verilog/wdt_pkg.sv ***
// Package for the watchdog timer: register byte offsets, field positions,
// reset values and tick divider counts.
// Assumes a byte-wide register port and a 200 MHz core clock.
package wdt_pkg;

  // Register byte addresses
  localparam logic [15:0] WDT_CTRL_LO   = 16'h3000; // Control, low byte
  localparam logic [15:0] WDT_CTRL_HI   = 16'h3001; // Control, high byte
  localparam logic [15:0] WDT_STROBE    = 16'h3002; // Reload strobe
  localparam logic [15:0] WATCHDOG_LIVE_COUNT_B0  = 16'h3004; // Live count, byte 0
  localparam logic [15:0] WATCHDOG_LIVE_COUNT_B3  = 16'h3007; // Live count, byte 3
  localparam logic [15:0] WATCHDOG_LOAD_VALUE_B0   = 16'h3008; // Load value, byte 0
  localparam logic [15:0] WATCHDOG_LOAD_VALUE_B3   = 16'h300B; // Load value, byte 3

  // Control field positions
  localparam int COUNTER_ENABLE_BIT    = 0; // Counter enable
  localparam int UNDERFLOW_STATUS_BIT   = 1; // Underflow status
  localparam int FAST_SIMULATION_SELECT_BIT   = 2; // Fast simulation select
  localparam int TICK_UNIT_SELECT_BIT = 3; // Tick unit select

  // Reset values
  localparam logic [31:0] WATCHDOG_LIVE_COUNT_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] WATCHDOG_LOAD_VALUE_RST  = 32'hFFFF_FFFF;

  // Tick sources and derived divider counts
  localparam int WDT_FAST_HZ   = 48_000_000; // Fast oscillator
  localparam int WDT_SLOW_HZ   = 20_000;     // Keep-alive oscillator
  localparam int WDT_US_PER_S  = 1_000_000;
  localparam int WDT_MS_PER_S  = 1_000;
  localparam int WDT_FAST_DIV  = WDT_FAST_HZ / WDT_US_PER_S; // 1 us
  localparam int WDT_SLOW_DIV  = WDT_SLOW_HZ / WDT_MS_PER_S; // 1 ms
  localparam logic [5:0] WDT_FAST_LAST = 6'(WDT_FAST_DIV - 1);
  localparam logic [5:0] WDT_SLOW_LAST = 6'(WDT_SLOW_DIV - 1);

  // Cycles after reset release before the reset cause is sampled
  localparam logic [1:0] WDT_CAUSE_WAIT = 2'h2;

endpackage : wdt_pkg

// *** verilog/wdt_timer.sv ***
// Watchdog timer: byte register port, tick generation from oscillator
// inputs, reload and enable crossing, underflow reset request.
// Assumes oscillator clocks and the reset cause arrive asynchronously and
// that the system reset generator acts on wdtResetReq.
//
// Function
// - Decode control, strobe, count, load offsets
// - Control bit 3 picks ms or us
// - us uses 48 MHz, ms 20 KHz
// - Control bit 2 runs 1 MHz clock
// - Status bit 1 marks watchdog reset
// - Status cleared only by writing one
// - Status after reset shows reset cause
// - Bit 0 enables counter, resets low
// - Enable change synchronised into timer side
// - Strobe write reloads counter when enabled
// - Strobe write ignored while disabled
// - Strobe register always reads zero
// - Reload request crosses into timer side
// - Live count read-only, resets all ones
// - Low byte read snapshots whole counter
// - Underflow requests reset, sets status
// - Writes other than control low byte blocked while status pending
`timescale 1ns/10ps

module wdt_timer
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [15:0] regAddr,
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regRdEn,
  output logic      [7:0]  regRdData,
  output logic             regRdValid,
  // Oscillator inputs, asynchronous
  input  wire logic        fastOscClk,
  input  wire logic        slowOscClk,
  input  wire logic        simOscClk,
  // Reset generator
  input  wire logic        lastResetByWdt,
  output logic             wdtResetReq,
  output logic             counterRunning
);

  // Control and data registers
  logic        counterEnable;        // Enable as written
  logic        fastSimulationSelect; // 1 MHz simulation source
  logic        tickUnitSelect;       // 0: ms, 1: us
  logic        underflowStatus;      // Sticky underflow flag
  logic [31:0] loadValue;            // Load value register
  logic [31:0] liveCount;            // Down counter
  logic [31:0] countSnap;            // Snapshot for bytes 1..3

  // Synchronisers
  logic [1:0]  enSync;      // Enable into timer side
  logic        kickToggle;  // Flips on each accepted strobe
  logic [2:0]  kickSync;    // Two stages plus edge history
  logic [2:0]  fastSync;    // Oscillator samplers plus history
  logic [2:0]  slowSync;
  logic [2:0]  simSync;
  logic [1:0]  causeSync;   // Reset cause sampler
  logic [1:0]  startCnt;    // Cycles since reset release
  logic        causeTaken;  // Reset cause captured once
  logic        enPrev;      // Synced enable, previous cycle
  logic        loadWritten; // Load register touched last cycle

  // Tick generation
  logic [5:0]  prescale;    // Oscillator edge counter
  logic        tick;        // One counter decrement step

  // Decode helpers
  logic        wrAllowed;
  logic        wrCtrl;
  logic        wrStrobe;
  logic        wrLoad;
  logic        kickApply;
  logic        underflow;

  // Writes are held off while an underflow is pending; control stays open
  // so software can clear the flag and unlock the port.
  assign wrAllowed = regWrEn
    && (!underflowStatus || regAddr == WDT_CTRL_LO);
  // Register selects; only the low control byte carries bits
  assign wrCtrl    = wrAllowed && regAddr == WDT_CTRL_LO;
  assign wrStrobe  = wrAllowed && regAddr == WDT_STROBE;
  assign wrLoad    = wrAllowed && regAddr >= WATCHDOG_LOAD_VALUE_B0
                     && regAddr <= WATCHDOG_LOAD_VALUE_B3;
  // Either edge of the crossed toggle is one reload request
  assign kickApply = kickSync[2] ^ kickSync[1];
  // A tick that finds the count at zero is the underflow
  assign underflow = tick && enSync[1] && liveCount == 32'h0000_0000;

  // Control bits; enable resets low
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      counterEnable        <= 1'b0;
      fastSimulationSelect <= 1'b0;
      tickUnitSelect       <= 1'b0;
    end else if (wrCtrl) begin
      // Bits 0, 2 and 3 taken; the status bit is handled apart
      counterEnable        <= regWrData[COUNTER_ENABLE_BIT];
      fastSimulationSelect <= regWrData[FAST_SIMULATION_SELECT_BIT];
      tickUnitSelect       <= regWrData[TICK_UNIT_SELECT_BIT];
    end
  end

  // Reset cause sampled after release, never loaded under reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      causeSync  <= 2'h0;
      startCnt   <= 2'h0;
      causeTaken <= 1'b0;
    end else begin
      // Cause pin is asynchronous, hence two stages
      causeSync <= {causeSync[0], lastResetByWdt};
      // Count to the sampling point, then stop
      if (startCnt != WDT_CAUSE_WAIT) begin
        startCnt <= startCnt + 2'h1;
      end
      if (startCnt == WDT_CAUSE_WAIT) begin
        causeTaken <= 1'b1;
      end
    end
  end

  // Underflow status: set wins over a write-one clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      underflowStatus <= 1'b0;
    end else if (underflow) begin
      underflowStatus <= 1'b1;
    end else if (!causeTaken && startCnt == WDT_CAUSE_WAIT
                 && causeSync[1]) begin
      // Cause seen once, after the synchroniser has settled
      underflowStatus <= 1'b1;
    end else if (wrCtrl && regWrData[UNDERFLOW_STATUS_BIT]) begin
      // Write-one clear; a zero leaves the flag alone
      underflowStatus <= 1'b0;
    end
  end

  // Load value, byte writable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      loadValue   <= WATCHDOG_LOAD_VALUE_RST;
      loadWritten <= 1'b0;
    end else begin
      loadWritten <= wrLoad;
      // Byte lane picked by the low address bits
      if (wrLoad) begin
        loadValue[8*regAddr[1:0] +: 8] <= regWrData;
      end
    end
  end

  // Strobe request toggles only while enabled
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      kickToggle <= 1'b0;
    end else if (wrStrobe && counterEnable) begin
      kickToggle <= ~kickToggle;
    end
  end

  // Crossing of enable and reload; first stages feed second only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      enSync   <= 2'h0;
      kickSync <= 3'h0;
      enPrev   <= 1'b0;
    end else begin
      enSync   <= {enSync[0], counterEnable};
      kickSync <= {kickSync[1:0], kickToggle};
      enPrev   <= enSync[1];
    end
  end

  // Oscillator samplers; stage two and three form the edge detector
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fastSync <= 3'h0;
      slowSync <= 3'h0;
      simSync  <= 3'h0;
    end else begin
      fastSync <= {fastSync[1:0], fastOscClk};
      slowSync <= {slowSync[1:0], slowOscClk};
      simSync  <= {simSync[1:0], simOscClk};
    end
  end

  // Tick prescaler. The simulation clock ticks on every rising edge; the
  // counter stays parked while disabled, standing in for gated clocks.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prescale <= 6'h00;
      tick     <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!enSync[1]) begin
        // Parked at zero so every start is aligned
        prescale <= 6'h00;
      end else if (fastSimulationSelect) begin
        tick <= simSync[1] && !simSync[2];
      end else if (tickUnitSelect) begin
        // Microsecond tick: count fast oscillator edges
        if (fastSync[1] && !fastSync[2]) begin
          if (prescale >= WDT_FAST_LAST) begin
            prescale <= 6'h00;
            tick     <= 1'b1;
          end else begin
            prescale <= prescale + 6'h01;
          end
        end
      end else if (slowSync[1] && !slowSync[2]) begin
        // Millisecond tick: count keep-alive edges
        if (prescale >= WDT_SLOW_LAST) begin
          prescale <= 6'h00;
          tick     <= 1'b1;
        end else begin
          prescale <= prescale + 6'h01;
        end
      end
    end
  end

  // Down counter: reload on activation, strobe, load write while stopped or underflow
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      liveCount <= WATCHDOG_LIVE_COUNT_RST;
    end else if (enSync[1] && !enPrev) begin
      liveCount <= loadValue;
    end else if (kickApply && enSync[1]) begin
      liveCount <= loadValue;
    end else if (loadWritten && !enSync[1]) begin
      // A load written while stopped shows in the count
      liveCount <= loadValue;
    end else if (underflow) begin
      // Underflow restarts the interval from the load
      liveCount <= loadValue;
    end else if (tick && enSync[1]) begin
      liveCount <= liveCount - 32'h0000_0001;
    end
  end

  // Reset request pulse and running indication
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wdtResetReq    <= 1'b0;
      counterRunning <= 1'b0;
    end else begin
      wdtResetReq    <= underflow;
      counterRunning <= enSync[1];
    end
  end

  // Count snapshot on low byte read keeps upper bytes coherent
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      countSnap <= WATCHDOG_LIVE_COUNT_RST;
    end else if (regRdEn && regAddr == WATCHDOG_LIVE_COUNT_B0) begin
      countSnap <= liveCount;
    end
  end

  // Read data, one cycle after the request; unmapped reads give zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      regRdData  <= 8'h00;
      if (regRdEn) begin
        if (regAddr == WDT_CTRL_LO) begin
          regRdData <= {4'h0, tickUnitSelect, fastSimulationSelect,
                        underflowStatus, counterEnable};
        end else if (regAddr == WDT_STROBE) begin
          regRdData <= 8'h00;
        end else if (regAddr == WATCHDOG_LIVE_COUNT_B0) begin
          regRdData <= liveCount[7:0];
        end else if (regAddr > WATCHDOG_LIVE_COUNT_B0
                     && regAddr <= WATCHDOG_LIVE_COUNT_B3) begin
          // Upper bytes from the snapshot, never live
          regRdData <= countSnap[8*regAddr[1:0] +: 8];
        end else if (regAddr >= WATCHDOG_LOAD_VALUE_B0
                     && regAddr <= WATCHDOG_LOAD_VALUE_B3) begin
          // Load value reads back as written
          regRdData <= loadValue[8*regAddr[1:0] +: 8];
        end
      end
    end
  end

endmodule : wdt_timer

// *** test/wdt_timer_checker.sv ***
// Checker for the watchdog timer ports.
// Assumes it is bound to wdt_timer; one clock domain.
`timescale 1ns/10ps
module wdt_timer_checker
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // Register port
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic        regRdValid,
  input wire logic [15:0] regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdData,
  // Timer outputs
  input wire logic        wdtResetReq,
  input wire logic        counterRunning
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Enable write as seen at the port
  wire enWr = regWrEn && regAddr == WDT_CTRL_LO && regWrData[COUNTER_ENABLE_BIT];

  chk_read_answer: assert property (regRdEn |=> regRdValid)
    else $error("read not answered");
  chk_idle_quiet: assert property (
    !regRdEn |=> !regRdValid && regRdData == 8'h00)
    else $error("read data without read");
  chk_strobe_zero: assert property (
    regRdEn && regAddr == WDT_STROBE |=> regRdData == 8'h00)
    else $error("strobe read not zero");
  chk_ctrl_reserved: assert property (
    regRdEn && regAddr == WDT_CTRL_LO |=> regRdData[7:4] == 4'h0)
    else $error("control upper bits set");
  chk_reserved_zero: assert property (
    regRdEn && regAddr >= 16'h300C && regAddr <= 16'h33FF
    |=> regRdData == 8'h00) else $error("reserved read not zero");
  // Crossing delay: start only a few cycles after the write
  chk_run_cause: assert property (
    $rose(counterRunning) |-> $past(enWr, 3) || $past(enWr, 4)
    || $past(enWr, 5)) else $error("counting began without enable");
  chk_req_pulse: assert property (wdtResetReq |=> !wdtResetReq)
    else $error("reset request too long");
  chk_req_running: assert property (
    wdtResetReq |-> $past(counterRunning) || $past(counterRunning, 2))
    else $error("reset request while stopped");
  // Main scenarios reached
  cover property (wdtResetReq);
  cover property ($rose(counterRunning));
  cover property (regRdEn && regAddr == WATCHDOG_LIVE_COUNT_B0);
endmodule : wdt_timer_checker

bind wdt_timer wdt_timer_checker u_chk (.mclk, .rstn, .regWrEn, .regRdEn,
  .regRdValid, .wdtResetReq, .counterRunning, .regAddr, .regWrData,
  .regRdData);

// *** test/test_watchdog_timer.sv ***
// Watchdog timer bench: byte register tasks, model, compares.
// Assumes sim oscillator stepped here; fast and slow run free.
`timescale 1ns/10ps
module test_watchdog_timer;
  import wdt_pkg::*;
  // Design ports
  logic        mclk = 1'b0, rstn = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0]  regWrData = 8'h00, regRdData;
  logic        regWrEn = 1'b0, regRdEn = 1'b0, regRdValid;
  logic        fastOscClk = 1'b0, slowOscClk = 1'b0, simOscClk = 1'b0;
  logic        lastResetByWdt = 1'b0, wdtResetReq, counterRunning;
  // Counters and model state
  int          n_errors = 0, checked = 0, nReq = 0;
  bit          mEn = 1'b0;
  logic [31:0] lfsr = 32'h670E, mLoad, mCnt, v;

  wdt_timer dut (.mclk, .rstn, .regAddr, .regWrEn, .regWrData, .regRdEn,
    .regRdData, .regRdValid, .fastOscClk, .slowOscClk, .simOscClk,
    .lastResetByWdt, .wdtResetReq, .counterRunning);

  // Core 200 MHz, fast near 48 MHz; slow sped up to 2 MHz so that a
  // millisecond tick (20 slow edges) lasts 10 us and fits the run
  initial forever #2.5 mclk = ~mclk;
  initial forever #10.4 fastOscClk = ~fastOscClk;
  initial forever #250 slowOscClk = ~slowOscClk;
  // Count reset request pulses
  always @(posedge mclk) if (wdtResetReq === 1'b1) nReq++;

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // Drives land 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  // Tolerance only for free-running tick phase
  task automatic chk(input string nm, input logic [31:0] e, g,
                     input int tol = 0);
    checked++;
    if (^g === 1'bx || g + tol < e || g > e + tol) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic [15:0] a, input logic [7:0] d);
    cyc(1);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    cyc(1);
    regWrEn = 1'b0;
  endtask : wb

  // Byte reads, low byte first
  task automatic rc(input string nm, input logic [15:0] a, input int n,
                    input logic [31:0] e, input int tol = 0);
    v = 32'h0;
    for (int i = 0; i < n; i++) begin
      cyc(1);
      regAddr = a + 16'(i);
      regRdEn = 1'b1;
      cyc(1);
      regRdEn = 1'b0;
      v[8*i +: 8] = (regRdValid === 1'b1) ? regRdData : 8'hEE;
    end
    chk(nm, e, v, tol);
  endtask : rc

  // One sim oscillator period; model follows
  task automatic tick();
    simOscClk = 1'b1;
    cyc(8);
    simOscClk = 1'b0;
    cyc(8);
    if (mEn && mCnt == 32'h0) mCnt = mLoad;
    else if (mEn) mCnt--;
  endtask : tick

  // Control write; enable rising edge reloads
  task automatic ctl(input logic [7:0] c);
    wb(WDT_CTRL_LO, c);
    cyc(6);
    if (c[COUNTER_ENABLE_BIT] && !mEn) mCnt = mLoad;
    mEn = c[COUNTER_ENABLE_BIT];
    chk("running", 32'(mEn), 32'(counterRunning));
  endtask : ctl

  task automatic ld(input logic [31:0] w);
    for (int i = 0; i < 4; i++) wb(WATCHDOG_LOAD_VALUE_B0 + 16'(i), w[8*i +: 8]);
    cyc(3);
    mLoad = w;
    mCnt = w;
  endtask : ld

  task automatic results();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  initial begin
    cyc(20);
    rstn = 1'b1;
    cyc(6);
    rc("ctrl", WDT_CTRL_LO, 2, 32'h0);
    rc("strobe", WDT_STROBE, 1, 32'h0);
    wb(WATCHDOG_LIVE_COUNT_B0, 8'h00);
    rc("count", WATCHDOG_LIVE_COUNT_B0, 4, 32'hFFFF_FFFF);
    rc("load", WATCHDOG_LOAD_VALUE_B0, 4, 32'hFFFF_FFFF);
    rc("rsvd", 16'h300C + 16'(rnd() % 1012), 1, 32'h0);
    $display("test reset done");
    ctl(8'h00);
    ld((rnd() & 32'h3) + 32'h2);
    ctl(8'h0D);
    rc("count", WATCHDOG_LIVE_COUNT_B0, 4, mCnt);
    repeat (2) begin
      tick();
      rc("count", WATCHDOG_LIVE_COUNT_B0, 4, mCnt);
    end
    v = rnd();
    wb(WDT_STROBE, v[7:0]);
    cyc(6);
    mCnt = mLoad;
    rc("count", WATCHDOG_LIVE_COUNT_B0, 4, mCnt);
    repeat (mLoad + 1) tick();
    chk("requests", 32'h1, 32'(nReq));
    rc("ctrl", WDT_CTRL_LO, 1, 32'h0F);
    rc("count", WATCHDOG_LIVE_COUNT_B0, 4, mCnt);
    wb(WATCHDOG_LOAD_VALUE_B0, 8'h55);
    rc("load", WATCHDOG_LOAD_VALUE_B0, 1, 32'(mLoad[7:0]));
    ctl(8'h0C);
    rc("ctrl", WDT_CTRL_LO, 1, 32'h0E);
    ctl(8'h0E);
    rc("ctrl", WDT_CTRL_LO, 1, 32'h0C);
    $display("test underflow done");
    ctl(8'h0D);
    repeat (2) tick();
    ctl(8'h0C);
    tick();
    rc("count", WATCHDOG_LIVE_COUNT_B0, 4, mCnt);
    wb(WDT_STROBE, 8'hA5);
    cyc(6);
    rc("count", WATCHDOG_LIVE_COUNT_B0, 4, mCnt);
    ld(32'h0000_0100);
    ctl(8'h0D);
    rc("snap", WATCHDOG_LIVE_COUNT_B0, 1, 32'h0);
    tick();
    rc("snap", WATCHDOG_LIVE_COUNT_B0 + 16'h1, 3, 32'h1);
    rc("count", WATCHDOG_LIVE_COUNT_B0, 4, mCnt);
    $display("test hold done");
    ctl(8'h00);
    ld(32'h0000_0064);
    ctl(8'h09);
    cyc(2000);
    rc("count", WATCHDOG_LIVE_COUNT_B0, 4, 32'h5A, 2);
    ctl(8'h00);
    ld(32'h0000_0064);
    ctl(8'h01);
    cyc(5000);
    rc("count", WATCHDOG_LIVE_COUNT_B0, 4, 32'h62);
    rstn = 1'b0;
    lastResetByWdt = 1'b1;
    cyc(20);
    rstn = 1'b1;
    cyc(8);
    lastResetByWdt = 1'b0;
    rc("ctrl", WDT_CTRL_LO, 1, 32'h02);
    $display("test units and cause done");
    results();
  end

  // Hang guard
  initial begin
    #300000;
    n_errors++;
    results();
  end
endmodule : test_watchdog_timer
